// ### module_uart_host_link.sv
// Full-duplex serial port between the module and its host, with flow control.
`timescale 1ns/1ns
`include "uart_link_map.svh"
module module_uart_host_link
  import uart_link_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        reset_pad,
  input  wire cfg_type     cfg,
  input  wire logic        link_connected_level,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output rx_word_type      rx_word,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic             rx_overrun,
  input  wire logic        multipurpose_line_five,
  output logic             multipurpose_line_two,
  output logic             line_two_oe_n,
  input  wire logic        cts_n,
  output logic             rts_n
);

  logic         rst_sync1_ff, rst_sync2_ff, core_rstn_ff, pad_rst_ff;
  logic [7:0]   pad_cnt_ff;
  logic [15:0]  half_div;
  logic [3:0]   nbits;
  tx_state_type tx_st_ff;
  rx_state_type rx_st_ff;
  logic [15:0]  tx_div_ff;
  logic         tx_phase_ff, tx_tick, tx_bit_end, tx_par_ff;
  logic [7:0]   tx_shift_ff;
  logic [3:0]   tx_cnt_ff, stop_halves;
  logic [16:0]  rx_div_ff;
  logic         rx_prev_ff, rx_tick, rx_fall, rx_push, rx_perr_ff, buf_in_ready;
  logic [7:0]   rx_shift_ff;
  logic [3:0]   rx_cnt_ff;
  logic         rx_expect;

  // External reset is released through two stages before the core sees it.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  // The pad must stay high for the latency count; short spikes are ignored.
  always_ff @(posedge mclk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      pad_cnt_ff <= 8'h00;
      pad_rst_ff <= 1'b0;
    end else if (!reset_pad) begin
      pad_cnt_ff <= 8'h00;
      pad_rst_ff <= 1'b0;
    end else if (pad_cnt_ff == 8'(`RST_LAT_CYC - 1)) begin
      pad_rst_ff <= 1'b1;
    end else begin
      pad_cnt_ff <= pad_cnt_ff + 8'h01;
    end
  end

  // The core reset is a register, so it never glitches from the pad logic.
  always_ff @(posedge mclk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      core_rstn_ff <= 1'b0;
    end else begin
      core_rstn_ff <= !pad_rst_ff;
    end
  end

  // Out-of-range divisors are clamped so the rate stays in the served band.
  assign half_div = (cfg.half_div < 16'(`HALF_DIV_MIN)) ? 16'(`HALF_DIV_MIN) :
                    (cfg.half_div > 16'(`HALF_DIV_MAX)) ? 16'(`HALF_DIV_MAX) :
                    cfg.half_div;
  assign nbits       = 4'(cfg.width_sel) + 4'h5;
  assign stop_halves = (cfg.stop == STOP_TWO) ? 4'h4 :
                       (cfg.stop == STOP_ONE_HALF) ? 4'h3 : 4'h2;

  // Transmit half-bit divider; held at zero between characters to align them.
  assign tx_tick    = tx_div_ff == half_div - 16'h0001;
  assign tx_bit_end = tx_tick && tx_phase_ff;
  always_ff @(posedge mclk or negedge core_rstn_ff) begin
    if (!core_rstn_ff) begin
      tx_div_ff   <= 16'h0000;
      tx_phase_ff <= 1'b0;
    end else if (tx_st_ff == TX_IDLE || tx_st_ff == TX_HOLD) begin
      tx_div_ff   <= 16'h0000;
      tx_phase_ff <= 1'b0;
    end else if (tx_tick) begin
      tx_div_ff   <= 16'h0000;
      tx_phase_ff <= !tx_phase_ff;
    end else begin
      tx_div_ff   <= tx_div_ff + 16'h0001;
    end
  end

  // Transmit sequencer; a taken word waits in HOLD until the host is ready.
  always_ff @(posedge mclk or negedge core_rstn_ff) begin
    if (!core_rstn_ff) begin
      tx_st_ff    <= TX_IDLE;
      tx_shift_ff <= 8'h00;
      tx_cnt_ff   <= 4'h0;
      tx_par_ff   <= 1'b0;
      tx_ready    <= 1'b0;
    end else begin
      unique case (tx_st_ff)
        TX_IDLE: begin
          tx_ready <= 1'b1;
          if (tx_valid && tx_ready) begin
            tx_ready    <= 1'b0;
            tx_shift_ff <= tx_data;
            tx_par_ff   <= (^(tx_data & 8'(~(8'hff << nbits)))) ^ (cfg.parity == PAR_ODD);
            tx_st_ff    <= TX_HOLD;
          end
        end
        TX_HOLD: begin
          if (!(cfg.flow_en && cts_n)) begin
            tx_st_ff <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_cnt_ff <= 4'h0;
            tx_st_ff  <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift_ff <= tx_shift_ff >> 1;
            tx_cnt_ff   <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == nbits - 4'h1) begin
              tx_cnt_ff <= 4'h0;
              tx_st_ff  <= (cfg.parity == PAR_NONE) ? TX_STOP : TX_PARITY;
            end
          end
        end
        TX_PARITY: begin
          if (tx_bit_end) begin
            tx_st_ff <= TX_STOP;
          end
        end
        TX_STOP: begin
          // Stop length is counted in half bits so that 1.5 is exact.
          if (tx_tick) begin
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == stop_halves - 4'h1) begin
              tx_st_ff <= TX_IDLE;
            end
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // Pin driver: the line idles high and is driven once the core leaves reset.
  always_ff @(posedge mclk or negedge core_rstn_ff) begin
    if (!core_rstn_ff) begin
      multipurpose_line_two <= 1'b1;
      line_two_oe_n         <= 1'b1;
    end else begin
      line_two_oe_n <= 1'b0;
      if (cfg.status_mode) begin
        multipurpose_line_two <= link_connected_level;
      end else begin
        unique case (tx_st_ff)
          TX_START:  multipurpose_line_two <= 1'b0;
          TX_DATA:   multipurpose_line_two <= tx_shift_ff[0];
          TX_PARITY: multipurpose_line_two <= tx_par_ff;
          default:   multipurpose_line_two <= 1'b1;
        endcase
      end
    end
  end

  // Receive timing restarts at each start edge; the first wait lands mid-bit.
  assign rx_fall = rx_prev_ff && !multipurpose_line_five;
  assign rx_tick = (rx_st_ff != RX_IDLE) && (rx_div_ff == 17'h00000);
  assign rx_push = (rx_st_ff == RX_STOP) && rx_tick;
  always_ff @(posedge mclk or negedge core_rstn_ff) begin
    if (!core_rstn_ff) begin
      rx_prev_ff <= 1'b1;
      rx_div_ff  <= 17'h00000;
    end else begin
      rx_prev_ff <= multipurpose_line_five;
      if (rx_st_ff == RX_IDLE) begin
        rx_div_ff <= 17'(half_div - 16'h0001);
      end else if (rx_tick) begin
        rx_div_ff <= 17'({half_div, 1'b0} - 17'h00001);
      end else begin
        rx_div_ff <= rx_div_ff - 17'h00001;
      end
    end
  end

  // Receive sequencer; it never looks at the transmit side.
  assign rx_expect = (^rx_shift_ff) ^ (cfg.parity == PAR_ODD);
  always_ff @(posedge mclk or negedge core_rstn_ff) begin
    if (!core_rstn_ff) begin
      rx_st_ff    <= RX_IDLE;
      rx_shift_ff <= 8'h00;
      rx_cnt_ff   <= 4'h0;
      rx_perr_ff  <= 1'b0;
    end else begin
      unique case (rx_st_ff)
        RX_IDLE: begin
          if (rx_fall) begin
            rx_shift_ff <= 8'h00;
            rx_perr_ff  <= 1'b0;
            rx_cnt_ff   <= 4'h0;
            rx_st_ff    <= RX_START;
          end
        end
        RX_START: begin
          // A start bit that is high again at mid-bit was a spike.
          if (rx_tick) begin
            rx_st_ff <= multipurpose_line_five ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_shift_ff[rx_cnt_ff[2:0]] <= multipurpose_line_five;
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == nbits - 4'h1) begin
              rx_st_ff <= (cfg.parity == PAR_NONE) ? RX_STOP : RX_PARITY;
            end
          end
        end
        RX_PARITY: begin
          if (rx_tick) begin
            rx_perr_ff <= multipurpose_line_five != rx_expect;
            rx_st_ff   <= RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop bit is checked; longer stops just look idle.
          if (rx_tick) begin
            rx_st_ff <= RX_IDLE;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  uart_rx_buffer #(
    .W     (10),
    .DEPTH (`BUF_DEPTH)
  ) u_rx_buffer (
    .mclk      (mclk),
    .rst_n     (core_rstn_ff),
    .in_data   ({rx_shift_ff, rx_perr_ff, !multipurpose_line_five}),
    .in_valid  (rx_push),
    .in_ready  (buf_in_ready),
    .out_data  (rx_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // Request-to-send drops back as soon as one word waits, keeping one slot
  // free for a character already on the wire; overrun flags a lost word.
  always_ff @(posedge mclk or negedge core_rstn_ff) begin
    if (!core_rstn_ff) begin
      rts_n      <= 1'b1;
      rx_overrun <= 1'b0;
    end else begin
      rts_n      <= cfg.flow_en && (rx_valid || !buf_in_ready);
      rx_overrun <= rx_push && !buf_in_ready;
    end
  end

  a_pad_latency: assert property (@(posedge mclk) disable iff (!rst_sync2_ff)
    $rose(reset_pad) |-> ##99 !pad_rst_ff) else $error("pad reset acted too early");
  a_pad_release: assert property (@(posedge mclk) disable iff (!rst_sync2_ff)
    !reset_pad |=> !pad_rst_ff ##1 core_rstn_ff) else $error("pad release lost");
  a_cts_hold: assert property (@(posedge mclk) disable iff (!core_rstn_ff)
    (tx_st_ff == TX_HOLD && cfg.flow_en && cts_n) |=> tx_st_ff == TX_HOLD)
    else $error("sent while peer not ready");
  a_rts_busy: assert property (@(posedge mclk) disable iff (!core_rstn_ff)
    (cfg.flow_en && rx_valid) |=> rts_n) else $error("rts low with word waiting");
  a_status_pin: assert property (@(posedge mclk) disable iff (!core_rstn_ff)
    cfg.status_mode |=> multipurpose_line_two == $past(link_connected_level))
    else $error("status level not on pin");
  a_start_low: assert property (@(posedge mclk) disable iff (!core_rstn_ff)
    (tx_st_ff == TX_START && !cfg.status_mode) |=> !multipurpose_line_two)
    else $error("start bit not low");
  a_rate_range: assert property (@(posedge mclk) disable iff (!core_rstn_ff)
    half_div >= 16'(`HALF_DIV_MIN) && half_div <= 16'(`HALF_DIV_MAX))
    else $error("divider out of range");
  a_rx_width: assert property (@(posedge mclk) disable iff (!core_rstn_ff)
    (rx_st_ff == RX_DATA && rx_tick && rx_cnt_ff == nbits - 4'h1) |=> rx_st_ff != RX_DATA)
    else $error("wrong character width");
  a_parity_skip: assert property (@(posedge mclk) disable iff (!core_rstn_ff)
    (tx_st_ff == TX_DATA && tx_bit_end && tx_cnt_ff == nbits - 4'h1 && cfg.parity == PAR_NONE)
    |=> tx_st_ff == TX_STOP) else $error("parity slot not skipped");
  a_rx_duplex: assert property (@(posedge mclk) disable iff (!core_rstn_ff)
    (rx_st_ff == RX_IDLE && rx_fall) |=> rx_st_ff == RX_START)
    else $error("receive start missed");

endmodule

// ### uart_link_map.svh
// Constants for the host link serial port: timing counts and reset values.
`ifndef UART_LINK_MAP_SVH
`define UART_LINK_MAP_SVH

`define CLK_HZ        50000000
`define BAUD_MIN      1200
`define BAUD_MAX      921600
`define BAUD_RST      115200
`define HALF_DIV_MIN  (`CLK_HZ / (2 * `BAUD_MAX))
`define HALF_DIV_MAX  (`CLK_HZ / (2 * `BAUD_MIN))
`define HALF_DIV_RST  (`CLK_HZ / (2 * `BAUD_RST))
`define RST_LAT_NS    2000
`define RST_LAT_CYC   ((`RST_LAT_NS * (`CLK_HZ / 1000000)) / 1000)
`define BUF_DEPTH     2
`define RX_BITS_MAX   8

`endif

// ### uart_link_pkg.sv
// Types shared by the host link serial port and its testbench.
package uart_link_pkg;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ODD  = 2'b01,
    PAR_EVEN = 2'b10
  } parity_type;

  typedef enum logic [1:0] {
    STOP_ONE      = 2'b00,
    STOP_ONE_HALF = 2'b01,
    STOP_TWO      = 2'b10
  } stop_type;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_HOLD   = 3'b001,
    TX_START  = 3'b010,
    TX_DATA   = 3'b011,
    TX_PARITY = 3'b100,
    TX_STOP   = 3'b101
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } rx_state_type;

  // Line settings; width_sel 0..3 selects 5..8 data bits.
  typedef struct packed {
    logic [15:0] half_div;
    logic [1:0]  width_sel;
    parity_type  parity;
    stop_type    stop;
    logic        flow_en;
    logic        status_mode;
  } cfg_type;

  typedef struct packed {
    logic [7:0] data;
    logic       parity_err;
    logic       frame_err;
  } rx_word_type;

endpackage

// ### uart_rx_buffer.sv
// Small shifting buffer with valid/ready on both sides and registered outputs.
`timescale 1ns/1ns
module uart_rx_buffer #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  // The count is five bits wide, so deeper buffers cannot be served.
  if (DEPTH < 2 || DEPTH > 16 || W < 1) begin : g_bad_cfg
    $error("uart_rx_buffer: unsupported depth or width");
  end

  logic [W-1:0] ent_ff [DEPTH];
  logic [4:0]   cnt_ff;
  logic         push;
  logic         pop;
  logic [4:0]   nxt_cnt;

  assign push    = in_valid && in_ready;
  assign pop     = out_valid && out_ready;
  assign nxt_cnt = 5'(cnt_ff + {4'h0, push} - {4'h0, pop});

  // Head sits in entry 0 so the output is a plain register; a pop shifts.
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic         hit;
    logic [W-1:0] nxt_ent;
    assign hit = push && (5'(i) == (pop ? 5'(cnt_ff - 5'h01) : cnt_ff));
    // The top entry has no neighbour above it, so a pop leaves it alone.
    if (i < DEPTH - 1) begin : g_mid
      assign nxt_ent = ent_ff[i+1];
    end else begin : g_top
      assign nxt_ent = ent_ff[i];
    end
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        ent_ff[i] <= '0;
      end else if (hit) begin
        ent_ff[i] <= in_data;
      end else if (pop) begin
        ent_ff[i] <= nxt_ent;
      end
    end
  end

  // Count and both flags move together so full and empty stay honest.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff    <= 5'h00;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      in_ready  <= nxt_cnt < 5'(DEPTH);
      out_valid <= nxt_cnt != 5'h00;
    end
  end

  assign out_data = ent_ff[0];

endmodule

// ### host_serial_model.sv
// Behavioural model of the host controller on the far side of the serial link.
`timescale 1ns/1ns
module host_serial_model (
  input  wire logic        mclk,
  input  wire logic [15:0] half_div,
  input  wire logic        flow_en,
  input  wire logic        rts_n,
  input  wire logic        tx_line,
  output logic             rx_line
);
  // The receive line idles high between frames.
  initial rx_line = 1'b1;

  // Drive one level for a number of half bit times.
  task automatic hold_line(input logic v, input int halves);
    rx_line = v;
    repeat (halves * half_div) @(negedge mclk);
  endtask

  // Send one frame; parity and stop may be broken on purpose.
  task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par,
                      input int stop_halves, input logic flip_par, input logic bad_stop);
    int   guard;
    logic p;
    guard = 0;
    // A deasserted request-to-send (high) stops the host before the next start bit.
    while (flow_en && rts_n && guard < 20000) begin
      @(negedge mclk);
      guard++;
    end
    hold_line(1'b0, 2);
    for (int i = 0; i < nb; i++) hold_line(d[i], 2);
    p = ^(d & ((1 << nb) - 1)) ^ par[0] ^ flip_par;
    if (par != 2'b00) hold_line(p, 2);
    hold_line(~bad_stop, stop_halves);
    hold_line(1'b1, 2);
  endtask

  // Capture one frame from the transmit line, sampling each bit at its middle.
  task automatic recv(output logic [7:0] d, output logic p, output logic s,
                      input int nb, input logic has_par);
    int guard;
    guard = 0;
    d = 8'h00;
    p = 1'b0;
    while (tx_line !== 1'b0 && guard < 20000) begin
      @(negedge mclk);
      guard++;
    end
    repeat (half_div) @(negedge mclk);
    for (int i = 0; i < nb; i++) begin
      repeat (2 * half_div) @(negedge mclk);
      d[i] = tx_line;
    end
    if (has_par) begin
      repeat (2 * half_div) @(negedge mclk);
      p = tx_line;
    end
    repeat (2 * half_div) @(negedge mclk);
    s = tx_line;
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the host link serial port.
`timescale 1ns/1ns
module testbench;
  import uart_link_pkg::*;
  typedef struct packed {
    logic [1:0] w;
    parity_type p;
    stop_type   s;
    logic [7:0] d;
  } row_type;

  logic        mclk, rstn, reset_pad, link_connected_level, tx_valid, tx_ready;
  logic        rx_valid, rx_ready, rx_overrun, multipurpose_line_five;
  logic        multipurpose_line_two, line_two_oe_n, cts_n, rts_n;
  logic [7:0]  tx_data, got_d;
  logic        got_p, got_s;
  cfg_type     cfg;
  rx_word_type rx_word;
  int          n_errors, n_compared;
  int          n_ovr = 0;
  int          ovr_base;
  // Released pin floats to its pull-up level.
  wire         tx_wire = line_two_oe_n ? 1'b1 : multipurpose_line_two;
  row_type     rows [4] = '{'{2'h0, PAR_NONE, STOP_ONE, 8'h15},
                            '{2'h1, PAR_ODD, STOP_ONE_HALF, 8'h2a},
                            '{2'h2, PAR_EVEN, STOP_TWO, 8'h4b},
                            '{2'h3, PAR_ODD, STOP_TWO, 8'ha5}};

  module_uart_host_link module_uart_host_link_i (.mclk(mclk), .rstn(rstn),
    .reset_pad(reset_pad), .cfg(cfg), .link_connected_level(link_connected_level),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
    .multipurpose_line_five(multipurpose_line_five),
    .multipurpose_line_two(multipurpose_line_two), .line_two_oe_n(line_two_oe_n),
    .cts_n(cts_n), .rts_n(rts_n));
  host_serial_model host_serial_model_i (.mclk(mclk), .half_div(cfg.half_div),
    .flow_en(cfg.flow_en), .rts_n(rts_n), .tx_line(tx_wire),
    .rx_line(multipurpose_line_five));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // The overrun flag is a one-cycle pulse, so every pulse is counted.
  always @(posedge mclk) if (rx_overrun === 1'b1) n_ovr <= n_ovr + 1;

  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_val(string n, logic [9:0] g, logic [9:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_word(rx_word_type e);
    int w;
    w = 0;
    while (rx_valid !== 1'b1 && w < 3000) begin
      @(negedge mclk);
      w++;
    end
    n_compared++;
    if (rx_word !== e || rx_valid !== 1'b1) begin
      n_errors++;
      $display("BAD rx_word expected %h seen %h", e, rx_word);
    end
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
    @(negedge mclk);
  endtask

  // Offer one word; ready is read settled, and the next rising edge takes it.
  task automatic tx_put(logic [7:0] d);
    int w;
    w = 0;
    tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && w < 3000) begin
      @(negedge mclk);
      w++;
    end
    if (w >= 3000) n_errors++;
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask

  task automatic wait_idle();
    int w;
    w = 0;
    while (tx_ready !== 1'b1 && w < 3000) begin
      @(negedge mclk);
      w++;
    end
    if (w >= 3000) n_errors++;
  endtask

  function automatic logic [7:0] mask(int nb);
    return 8'((1 << nb) - 1);
  endfunction

  // Both directions run at once: a word goes out while another comes in.
  task automatic run_row(row_type r, logic [7:0] hd);
    int nb;
    nb = r.w + 5;
    cfg.width_sel = r.w;
    cfg.parity = r.p;
    cfg.stop = r.s;
    fork
      tx_put(r.d);
      host_serial_model_i.recv(got_d, got_p, got_s, nb, r.p != PAR_NONE);
      host_serial_model_i.send(hd, nb, r.p, (r.s == STOP_ONE) ? 2 : (r.s == STOP_TWO) ? 4 : 3,
                               1'b0, 1'b0);
    join
    chk_val("tx data", got_d, r.d & mask(nb));
    if (r.p != PAR_NONE) chk_val("tx parity", got_p, ^(r.d & mask(nb)) ^ r.p[0]);
    chk_val("tx stop", got_s, 1);
    chk_word('{hd & mask(nb), 1'b0, 1'b0});
    wait_idle();
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    rstn = 1'b0;
    reset_pad = 1'b0;
    cfg = '{16'h001b, 2'h3, PAR_NONE, STOP_ONE, 1'b0, 1'b0};
    link_connected_level = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    cts_n = 1'b0;
    repeat (6) @(negedge mclk);
    chk_val("tx_ready", tx_ready, 0);
    chk_val("rts_n", rts_n, 1);
    chk_val("oe_n", line_two_oe_n, 1);
    rstn = 1'b1;
    repeat (5) @(negedge mclk);
    chk_val("tx_ready", tx_ready, 1);
    chk_val("oe_n", line_two_oe_n, 0);
    for (int i = 0; i < 4; i++) run_row(rows[i], rows[i].d ^ 8'h3c);
    // Broken parity, then a low stop bit.
    cfg.parity = PAR_EVEN;
    cfg.width_sel = 2'h3;
    host_serial_model_i.send(8'h81, 8, 2'b10, 2, 1'b1, 1'b0);
    chk_word('{8'h81, 1'b1, 1'b0});
    host_serial_model_i.send(8'h7e, 8, 2'b10, 2, 1'b0, 1'b1);
    chk_word('{8'h7e, 1'b0, 1'b1});
    // Fill the buffer without reading; the third word must be refused.
    cfg.parity = PAR_NONE;
    ovr_base = n_ovr;
    host_serial_model_i.send(8'h11, 8, 2'b00, 2, 1'b0, 1'b0);
    host_serial_model_i.send(8'h22, 8, 2'b00, 2, 1'b0, 1'b0);
    chk_val("overrun early", 10'(n_ovr - ovr_base), 0);
    host_serial_model_i.send(8'h33, 8, 2'b00, 2, 1'b0, 1'b0);
    chk_val("overrun", 10'(n_ovr - ovr_base), 1);
    chk_word('{8'h11, 1'b0, 1'b0});
    chk_word('{8'h22, 1'b0, 1'b0});
    chk_val("rx_valid empty", rx_valid, 0);
    // Flow control on: a held word deasserts request-to-send.
    cfg.flow_en = 1'b1;
    host_serial_model_i.send(8'h5a, 8, 2'b00, 2, 1'b0, 1'b0);
    chk_val("rts_n full", rts_n, 1);
    chk_word('{8'h5a, 1'b0, 1'b0});
    repeat (3) @(negedge mclk);
    chk_val("rts_n empty", rts_n, 0);
    // Clear-to-send high holds the frame back.
    cts_n = 1'b1;
    tx_put(8'hc3);
    repeat (200) @(negedge mclk);
    chk_val("held line", tx_wire, 1);
    fork
      host_serial_model_i.recv(got_d, got_p, got_s, 8, 1'b0);
      cts_n = 1'b0;
    join
    chk_val("released data", got_d, 8'hc3);
    wait_idle();
    cfg.status_mode = 1'b1;
    repeat (3) @(negedge mclk);
    chk_val("status low", tx_wire, 0);
    link_connected_level = 1'b1;
    repeat (3) @(negedge mclk);
    chk_val("status high", tx_wire, 1);
    cfg.status_mode = 1'b0;
    cfg.flow_en = 1'b0;
    // A short pad pulse is ignored; a long one resets after its latency.
    reset_pad = 1'b1;
    repeat (50) @(negedge mclk);
    reset_pad = 1'b0;
    repeat (5) @(negedge mclk);
    chk_val("short pad", tx_ready, 1);
    reset_pad = 1'b1;
    repeat (95) @(negedge mclk);
    chk_val("pad early", tx_ready, 1);
    repeat (15) @(negedge mclk);
    chk_val("pad tx_ready", tx_ready, 0);
    chk_val("pad rts_n", rts_n, 1);
    reset_pad = 1'b0;
    repeat (6) @(negedge mclk);
    chk_val("pad release", tx_ready, 1);
    run_row(rows[3], 8'h99);
    tally_and_finish();
  end
endmodule
